// >>> inc/lbv_consts.svh
// Constants for the lock and bus voltage fault configuration block.
`ifndef LBV_CONSTS_SVH
`define LBV_CONSTS_SVH

// Register byte addresses.
`define LBV_ADDR_CFG    8'h00
`define LBV_ADDR_STS    8'h04
`define LBV_ADDR_ICLR   8'h08
`define LBV_ADDR_IEN    8'h0c
`define LBV_ADDR_CTRL   8'h10
`define LBV_ADDR_FSTAT  8'h14

// Configuration field positions and reset value.
`define LBV_CFG_RESET     22'h000000
`define LBV_F_THR_HI      21
`define LBV_F_THR_LO      19
`define LBV_F_MODE_HI     18
`define LBV_F_MODE_LO     15
`define LBV_F_DEG_HI      14
`define LBV_F_DEG_LO      12
`define LBV_F_HYS         11
`define LBV_F_UV_HI       10
`define LBV_F_UV_LO       8
`define LBV_F_UV_AUTO     7
`define LBV_F_OV_HI       6
`define LBV_F_OV_LO       4
`define LBV_F_OV_AUTO     3
`define LBV_F_RETRY_HI    2
`define LBV_F_RETRY_LO    0

// Status bit positions.
`define LBV_S_LOCK     0
`define LBV_S_LATCH    1
`define LBV_S_UV       2
`define LBV_S_OV       3

// Response codes.
`define LBV_MODE_AUTO   4'h4
`define LBV_MODE_REPORT 4'h8

// Timing: clock rate, filter step and lock retry interval.
`define LBV_CLK_MHZ        250
`define LBV_DEG_STEP_US    1
`define LBV_DEG_STEP_CYC   (`LBV_DEG_STEP_US * `LBV_CLK_MHZ)
`define LBV_LOCK_RETRY_US  1000
`define LBV_LOCK_RETRY_CYC (`LBV_LOCK_RETRY_US * `LBV_CLK_MHZ)

`endif

// >>> inc/lbv_pkg.sv
// Types shared by the lock and bus voltage fault block.
package lbv_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } lbv_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lbv_apb_rsp_type;

  typedef struct packed {
    logic tristate;
    logic low_brake;
  } lbv_gate_type;

  typedef struct packed {
    logic [10:0] count;
    logic        out;
  } lbv_deg_state_type;

  typedef struct packed {
    logic fault;
    logic evt;
  } lbv_volt_state_type;

  typedef struct packed {
    logic [21:0] cfg;
    logic [3:0]  sts;
    logic [3:0]  ien;
    logic        lock_fault;
    logic        lock_latched;
    logic        lock_brake;
    logic        lock_seen;
    logic [4:0]  retry_cnt;
    logic [19:0] retry_timer;
  } lbv_top_state_type;

endpackage : lbv_pkg

// >>> tb/lbv_top_tb_top.sv
// Self-checking testbench for the lock and bus voltage fault block.
`timescale 1ns/1ns
`default_nettype none
`include "lbv_consts.svh"
module lbv_top_tb_top;
  import lbv_pkg::*;
  logic            pclk;
  logic            presetn;
  lbv_apb_req_type apb_req;
  lbv_apb_rsp_type apb_rsp;
  logic            lock_detect_in;
  logic [9:0]      bus_volt_dv;
  logic [7:0]      thr;
  lbv_gate_type    gate_ctrl;
  logic            fault_output_pin_n;
  logic            irq;
  logic [31:0]     rd;
  logic [31:0]     rv;
  logic            err;
  int              n_mismatch;
  int              compares;

  // Design with a short retry interval.
  lbv_top #(.LOCK_RETRY_CYCLES(20)) i_lbv_top (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .apb_req                    (apb_req),
    .apb_rsp                    (apb_rsp),
    .lock_detect_in             (lock_detect_in),
    .bus_volt_dv                (bus_volt_dv),
    .no_load_lock_threshold_pml (thr),
    .gate_ctrl                  (gate_ctrl),
    .fault_output_pin_n         (fault_output_pin_n),
    .irq                        (irq)
  );

  // The clock runs at 250 MHz.
  always #2 pclk = ~pclk;

  // Expected decodes of the threshold fields.
  function automatic logic [9:0] lim(input logic ov, input logic [2:0] c);
    logic [9:0] u [8];
    logic [9:0] o [8];
    u = '{10'h000, 10'h032, 10'h03c, 10'h046, 10'h050, 10'h064, 10'h078, 10'h096};
    o = '{10'h000, 10'h064, 10'h096, 10'h0dc, 10'h140, 10'h190, 10'h1f4, 10'h258};
    return ov ? o[c] : u[c];
  endfunction : lim

  function automatic logic [7:0] pml(input logic [2:0] c);
    logic [7:0] t [8];
    t = '{8'h0a, 8'h14, 8'h1e, 8'h28, 8'h32, 8'h4b, 8'h64, 8'hc8};
    return t[c];
  endfunction : pml

  // Builds a configuration word from its fields.
  function automatic logic [31:0] mk(input logic [3:0] m, input logic [2:0] dg, input logic h,
                                     input logic [2:0] u, input logic ua, input logic [2:0] o,
                                     input logic oa, input logic [2:0] rt);
    return {13'h0000, m, dg, h, u, ua, o, oa, rt};
  endfunction : mk

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Compares tristate, brake and fault pin after letting an edge land.
  task automatic chkst(input logic [2:0] exp);
    @(posedge pclk);
    chk({29'h0, gate_ctrl.tristate, gate_ctrl.low_brake, fault_output_pin_n}, {29'h0, exp});
  endtask : chkst

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      wrap_up();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic lk(input int n);
    @(posedge pclk);
    lock_detect_in <= 1'b1;
    repeat (n) @(posedge pclk);
    lock_detect_in <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : lk

  // One bus voltage threshold in auto then latch recovery.
  task automatic vt(input logic ov, input logic [2:0] c, input logic h);
    logic [9:0] t;
    logic [9:0] hy;
    logic [9:0] e;
    t = lim(ov, c);
    hy = ov ? (h ? 10'd20 : 10'd10) : (h ? 10'd10 : 10'd5);
    e = ov ? t - hy : t + hy;
    for (int a = 1; a >= 0; a--) begin
      wr(`LBV_ADDR_CFG, ov ? mk(4'h9, 0, h, 0, 0, c, a[0], 0) : mk(4'h9, 0, h, c, a[0], 0, 0, 0));
      bus_volt_dv <= ov ? t + 10'd1 : t - 10'd1;
      repeat (2) @(posedge pclk);
      chkst(3'b100);
      bus_volt_dv <= e;
      repeat (2) @(posedge pclk);
      chkst(3'b100);
      bus_volt_dv <= ov ? e - 10'd1 : e + 10'd1;
      repeat (2) @(posedge pclk);
      chkst(a ? 3'b001 : 3'b100);
      apb(1'b0, `LBV_ADDR_STS, 0);
      chk(rd[2 + ov], 1'b1);
      wr(`LBV_ADDR_CTRL, 1);
      chkst(3'b001);
      wr(`LBV_ADDR_ICLR, 32'hf);
    end
  endtask : vt

  // Main sequence of scenarios.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    apb_req = '0;
    lock_detect_in = 1'b0;
    bus_volt_dv = 10'h078;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(30));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chkst(3'b001);
    chk({24'h0, thr}, 32'h0a);
    for (int c = 0; c < 8; c++) begin
      wr(`LBV_ADDR_CFG, {10'h0, c[2:0], 19'h0});
      @(posedge pclk);
      chk({24'h0, thr}, {24'h0, pml(c[2:0])});
    end
    // Random configurations read back through the low 22 bits.
    repeat (8) begin
      rv = $urandom;
      wr(`LBV_ADDR_CFG, rv);
      apb(1'b0, `LBV_ADDR_CFG, 0);
      chk(rd, {10'h0, rv[21:0]});
    end
    wr(`LBV_ADDR_CFG, 0);
    wr(`LBV_ADDR_CTRL, 1);
    wr(`LBV_ADDR_ICLR, 32'hf);
    wr(8'h40, 32'hffffffff);
    chk(err, 1'b1);
    apb(1'b0, 8'h40, 0);
    chk({err, rd}, {1'b1, 32'h0});
    // Disabled and undefined response codes take no action.
    for (int m = 9; m < 16; m++) begin
      wr(`LBV_ADDR_CFG, mk(m[3:0], 0, 0, 0, 0, 0, 0, 0));
      lk(5);
      apb(1'b0, `LBV_ADDR_STS, 0);
      chk(rd, 0);
      chkst(3'b001);
    end
    wr(`LBV_ADDR_CFG, mk(4'h8, 0, 0, 0, 0, 0, 0, 0));
    lk(5);
    apb(1'b0, `LBV_ADDR_STS, 0);
    chk(rd[0], 1'b1);
    chk({30'h0, gate_ctrl}, 0);
    wr(`LBV_ADDR_ICLR, 32'hf);
    // Latched and auto-clearing response codes.
    for (int m = 0; m < 8; m++) begin
      wr(`LBV_ADDR_CFG, mk(m[3:0], 0, 0, 0, 0, 0, 0, 0));
      lk(5);
      chkst(m[1] ? 3'b010 : 3'b100);
      repeat (40) @(posedge pclk);
      chkst(m[2] ? 3'b001 : (m[1] ? 3'b010 : 3'b100));
      wr(`LBV_ADDR_CTRL, 1);
      chkst(3'b001);
    end
    // Limit of two retries: the third lock latches the brake.
    wr(`LBV_ADDR_CFG, mk(4'h6, 0, 0, 0, 0, 0, 0, 3'h1));
    repeat (3) begin
      lk(5);
      repeat (40) @(posedge pclk);
    end
    chkst(3'b010);
    apb(1'b0, `LBV_ADDR_FSTAT, 0);
    chk(rd[3], 1'b1);
    chk(rd[8:4], 5'h02);
    wr(`LBV_ADDR_CTRL, 1);
    // One-step filter rejects a short pulse and passes a long one.
    wr(`LBV_ADDR_CFG, mk(4'h0, 3'h1, 0, 0, 0, 0, 0, 0));
    lk(200);
    chkst(3'b001);
    lk(300);
    chkst(3'b100);
    wr(`LBV_ADDR_CTRL, 1);
    // Interrupt raised, cleared and masked, with the filter off again.
    wr(`LBV_ADDR_CFG, 0);
    wr(`LBV_ADDR_ICLR, 32'hf);
    wr(`LBV_ADDR_IEN, 1);
    lk(5);
    chk(irq, 1'b1);
    wr(`LBV_ADDR_ICLR, 1);
    @(posedge pclk);
    chk(irq, 1'b0);
    wr(`LBV_ADDR_IEN, 0);
    lk(5);
    chk(irq, 1'b0);
    wr(`LBV_ADDR_CTRL, 1);
    wr(`LBV_ADDR_ICLR, 32'hf);
    for (int c = 1; c < 8; c++) begin
      vt(1'b0, c[2:0], $urandom_range(1, 0));
      vt(1'b1, c[2:0], $urandom_range(1, 0));
    end
    // A mid-run reset drops a latched brake and restores the defaults.
    wr(`LBV_ADDR_CFG, mk(4'h2, 0, 0, 0, 0, 0, 0, 0));
    lk(5);
    chkst(3'b010);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chkst(3'b001);
    apb(1'b0, `LBV_ADDR_CFG, 0);
    chk(rd, 0);
    wrap_up();
  end
endmodule : lbv_top_tb_top
`default_nettype wire

// >>> verilog/lbv_deglitch.sv
// Deglitch filter for the overcurrent lock indication.
`timescale 1ns/1ns
`default_nettype none
`include "lbv_consts.svh"
module lbv_deglitch (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       raw_in,
  input  wire logic [2:0] filter_code,
  output logic            filt_out
);
  import lbv_pkg::*;

  lbv_deg_state_type r_reg;
  lbv_deg_state_type r_next;
  logic [10:0]       limit;

  // The input must stay high for the selected number of microseconds.
  always_comb begin
    limit  = 11'(filter_code * `LBV_DEG_STEP_CYC);
    r_next = r_reg;
    if (!raw_in) begin
      r_next.count = 11'h000;
      r_next.out   = 1'b0;
    end else if (filter_code == 3'h0 || r_reg.count >= limit - 11'h001) begin
      r_next.out = 1'b1;
    end else begin
      r_next.count = r_reg.count + 11'h001;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign filt_out = r_reg.out;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A dropped input clears the output on the next clock edge.
  a_filter_drop: assert property (!raw_in |=> !filt_out)
    else $error("lock filter output outlived its input");
  // With a 1 us setting the input was high 250 cycles earlier.
  a_filter_time: assert property (filter_code == 3'h1 && $stable(filter_code) && $rose(filt_out)
                                  |-> $past(raw_in, 250))
    else $error("lock filter released too early");
endmodule : lbv_deglitch
`default_nettype wire

// >>> verilog/lbv_top.sv
// Lock response and bus voltage fault configuration with APB registers.
`timescale 1ns/1ns
`default_nettype none
`include "lbv_consts.svh"
module lbv_top #(
  parameter int unsigned LOCK_RETRY_CYCLES = `LBV_LOCK_RETRY_CYC
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire lbv_pkg::lbv_apb_req_type apb_req,
  output lbv_pkg::lbv_apb_rsp_type      apb_rsp,
  input  wire logic                     lock_detect_in,
  input  wire logic [9:0]               bus_volt_dv,
  output logic [7:0]                    no_load_lock_threshold_pml,
  output lbv_pkg::lbv_gate_type         gate_ctrl,
  output logic                          fault_output_pin_n,
  output logic                          irq
);
  import lbv_pkg::*;

  // ==========================================================================
  // Declarations
  lbv_top_state_type r_reg;
  lbv_top_state_type r_next;
  logic [3:0]        overcurrent_lock_response;
  logic [4:0]        retry_limit;
  logic [9:0]        uv_thr_dv;
  logic [9:0]        ov_thr_dv;
  logic [9:0]        uv_hys_dv;
  logic [9:0]        ov_hys_dv;
  logic              lock_filt;
  logic              lock_evt;
  logic              lock_en;
  logic              uv_fault;
  logic              ov_fault;
  logic              uv_evt;
  logic              ov_evt;
  logic              wr;
  logic              sw_clear;
  logic [3:0]        sts_clr;
  logic [31:0]       rdata;
  logic              addr_err;

  // ==========================================================================
  // Field decoding

  // Field views of the configuration register.
  assign overcurrent_lock_response = r_reg.cfg[`LBV_F_MODE_HI:`LBV_F_MODE_LO];

  // No-load threshold in tenths of a percent of the reference current scale.
  always_comb begin
    case (r_reg.cfg[`LBV_F_THR_HI:`LBV_F_THR_LO])
      3'h0:    no_load_lock_threshold_pml = 8'h0a;
      3'h1:    no_load_lock_threshold_pml = 8'h14;
      3'h2:    no_load_lock_threshold_pml = 8'h1e;
      3'h3:    no_load_lock_threshold_pml = 8'h28;
      3'h4:    no_load_lock_threshold_pml = 8'h32;
      3'h5:    no_load_lock_threshold_pml = 8'h4b;
      3'h6:    no_load_lock_threshold_pml = 8'h64;
      default: no_load_lock_threshold_pml = 8'hc8;
    endcase
  end

  // Retry attempt limit, zero meaning unlimited.
  always_comb begin
    case (r_reg.cfg[`LBV_F_RETRY_HI:`LBV_F_RETRY_LO])
      3'h0:    retry_limit = 5'h00;
      3'h1:    retry_limit = 5'h02;
      3'h2:    retry_limit = 5'h03;
      3'h3:    retry_limit = 5'h05;
      3'h4:    retry_limit = 5'h07;
      3'h5:    retry_limit = 5'h0a;
      3'h6:    retry_limit = 5'h0f;
      default: retry_limit = 5'h14;
    endcase
  end

  // Undervoltage threshold in tenths of a volt, zero meaning no limit.
  always_comb begin
    case (r_reg.cfg[`LBV_F_UV_HI:`LBV_F_UV_LO])
      3'h0:    uv_thr_dv = 10'h000;
      3'h1:    uv_thr_dv = 10'h032;
      3'h2:    uv_thr_dv = 10'h03c;
      3'h3:    uv_thr_dv = 10'h046;
      3'h4:    uv_thr_dv = 10'h050;
      3'h5:    uv_thr_dv = 10'h064;
      3'h6:    uv_thr_dv = 10'h078;
      default: uv_thr_dv = 10'h096;
    endcase
  end

  // Overvoltage threshold in tenths of a volt, zero meaning no limit.
  always_comb begin
    case (r_reg.cfg[`LBV_F_OV_HI:`LBV_F_OV_LO])
      3'h0:    ov_thr_dv = 10'h000;
      3'h1:    ov_thr_dv = 10'h064;
      3'h2:    ov_thr_dv = 10'h096;
      3'h3:    ov_thr_dv = 10'h0dc;
      3'h4:    ov_thr_dv = 10'h140;
      3'h5:    ov_thr_dv = 10'h190;
      3'h6:    ov_thr_dv = 10'h1f4;
      default: ov_thr_dv = 10'h258;
    endcase
  end

  // Recovery hysteresis in tenths of a volt.
  assign uv_hys_dv = r_reg.cfg[`LBV_F_HYS] ? 10'h00a : 10'h005;
  assign ov_hys_dv = r_reg.cfg[`LBV_F_HYS] ? 10'h014 : 10'h00a;

  // ==========================================================================
  // Fault detectors

  // Lock indication filter.
  lbv_deglitch u_deglitch (
    .pclk        (pclk),
    .presetn     (presetn),
    .raw_in      (lock_detect_in),
    .filter_code (r_reg.cfg[`LBV_F_DEG_HI:`LBV_F_DEG_LO]),
    .filt_out    (lock_filt)
  );

  // Undervoltage side of the bus window.
  lbv_volt_window #(.OVER(1'b0)) u_uv (
    .pclk         (pclk),
    .presetn      (presetn),
    .volt_dv      (bus_volt_dv),
    .thr_dv       (uv_thr_dv),
    .hys_dv       (uv_hys_dv),
    .auto_recover (r_reg.cfg[`LBV_F_UV_AUTO]),
    .sw_clear     (sw_clear),
    .fault        (uv_fault),
    .fault_evt    (uv_evt)
  );

  // Overvoltage side of the bus window.
  lbv_volt_window #(.OVER(1'b1)) u_ov (
    .pclk         (pclk),
    .presetn      (presetn),
    .volt_dv      (bus_volt_dv),
    .thr_dv       (ov_thr_dv),
    .hys_dv       (ov_hys_dv),
    .auto_recover (r_reg.cfg[`LBV_F_OV_AUTO]),
    .sw_clear     (sw_clear),
    .fault        (ov_fault),
    .fault_evt    (ov_evt)
  );

  // ==========================================================================
  // Bus decode

  // Writes take effect in the access phase; the slave never waits.
  assign wr       = apb_req.psel && apb_req.penable && apb_req.pwrite && !addr_err;
  assign sw_clear = wr && apb_req.paddr == `LBV_ADDR_CTRL && apb_req.pwdata[0];
  assign sts_clr  = (wr && apb_req.paddr == `LBV_ADDR_ICLR) ? apb_req.pwdata[3:0] : 4'h0;

  // Only codes 0 to 8 arm the lock detector.
  assign lock_en  = overcurrent_lock_response <= `LBV_MODE_REPORT;
  assign lock_evt = lock_filt && !r_reg.lock_seen && lock_en;

  // ==========================================================================
  // Next state

  // Register writes, lock response, retry timing and sticky status.
  always_comb begin
    r_next           = r_reg;
    r_next.lock_seen = lock_filt;
    if (wr && apb_req.paddr == `LBV_ADDR_CFG) begin
      r_next.cfg = apb_req.pwdata[21:0];
    end
    if (wr && apb_req.paddr == `LBV_ADDR_IEN) begin
      r_next.ien = apb_req.pwdata[3:0];
    end
    // Software clear drops the lock fault and restarts retry counting.
    if (sw_clear) begin
      r_next.lock_fault   = 1'b0;
      r_next.lock_latched = 1'b0;
      r_next.retry_cnt    = 5'h00;
    end
    // Auto-clear after the retry interval, counting the attempt.
    if (r_reg.lock_fault && !r_reg.lock_latched && !sw_clear) begin
      if (r_reg.retry_timer <= 20'h00001) begin
        r_next.lock_fault = 1'b0;
        if (r_reg.retry_cnt != 5'h1f) begin
          r_next.retry_cnt = r_reg.retry_cnt + 5'h01;
        end
      end else begin
        r_next.retry_timer = r_reg.retry_timer - 20'h00001;
      end
    end
    // A new lock starts a fault unless only reporting is wanted.
    if (lock_evt && overcurrent_lock_response < `LBV_MODE_REPORT && !r_reg.lock_fault) begin
      r_next.lock_fault  = 1'b1;
      r_next.lock_brake  = overcurrent_lock_response[1];
      r_next.retry_timer = 20'(LOCK_RETRY_CYCLES);
      if (overcurrent_lock_response < `LBV_MODE_AUTO) begin
        r_next.lock_latched = 1'b1;
      end else if (retry_limit != 5'h00 && r_next.retry_cnt >= retry_limit) begin
        r_next.lock_latched = 1'b1;
      end
    end
    // Status clear by write, while a same-cycle event still sets.
    r_next.sts                = r_reg.sts & ~sts_clr;
    r_next.sts[`LBV_S_LOCK]  |= lock_evt;
    r_next.sts[`LBV_S_LATCH] |= r_next.lock_latched && !r_reg.lock_latched;
    r_next.sts[`LBV_S_UV]    |= uv_evt;
    r_next.sts[`LBV_S_OV]    |= ov_evt;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg     <= '0;
      r_reg.cfg <= `LBV_CFG_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Read path and outputs

  // Read data multiplexer; write-only registers read as zero.
  always_comb begin
    rdata    = 32'h00000000;
    addr_err = 1'b0;
    if (apb_req.paddr == `LBV_ADDR_CFG) begin
      rdata = {10'h000, r_reg.cfg};
    end else if (apb_req.paddr == `LBV_ADDR_STS) begin
      rdata = {28'h0000000, r_reg.sts};
    end else if (apb_req.paddr == `LBV_ADDR_IEN) begin
      rdata = {28'h0000000, r_reg.ien};
    end else if (apb_req.paddr == `LBV_ADDR_ICLR || apb_req.paddr == `LBV_ADDR_CTRL) begin
      rdata = 32'h00000000;
    end else if (apb_req.paddr == `LBV_ADDR_FSTAT) begin
      rdata = {23'h000000, r_reg.retry_cnt, r_reg.lock_latched, r_reg.lock_fault, ov_fault, uv_fault};
    end else begin
      addr_err = 1'b1;
    end
  end

  assign apb_rsp.prdata  = rdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && addr_err;

  // Gate state: voltage faults tristate, lock faults follow the chosen response.
  assign gate_ctrl.tristate  = uv_fault || ov_fault || (r_reg.lock_fault && !r_reg.lock_brake);
  assign gate_ctrl.low_brake = r_reg.lock_fault && r_reg.lock_brake && !uv_fault && !ov_fault;
  assign fault_output_pin_n  = !(r_reg.lock_fault || uv_fault || ov_fault);
  assign irq                 = |(r_reg.sts & r_reg.ien);

  // ==========================================================================
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_thr_code_five: assert property (r_reg.cfg[21:19] == 3'h5 |-> no_load_lock_threshold_pml == 8'h4b)
    else $error("no-load threshold code 5 is not 7.5 percent");
  a_latch_tristate: assert property (lock_evt && overcurrent_lock_response < 4'h2 && !r_reg.lock_fault
    |=> r_reg.lock_latched && gate_ctrl.tristate && !fault_output_pin_n)
    else $error("latched tristate lock response missing");
  a_latch_brake: assert property (lock_evt && overcurrent_lock_response inside {4'h2, 4'h3}
    && !r_reg.lock_fault && !uv_fault && !ov_fault |=> r_reg.lock_latched && gate_ctrl.low_brake)
    else $error("latched brake lock response missing");
  a_auto_clear: assert property ($fell(r_reg.lock_fault) && !$past(sw_clear)
    |-> !$past(r_reg.lock_latched) && $past(r_reg.retry_timer) == 20'h00001)
    else $error("lock fault cleared before its retry interval");
  a_retry_limit: assert property (lock_evt && overcurrent_lock_response inside {[4'h4:4'h7]}
    && !r_reg.lock_fault && !sw_clear && retry_limit != 5'h00 && r_reg.retry_cnt >= retry_limit
    |=> r_reg.lock_latched)
    else $error("retry limit exceeded without latching");
  a_report_only: assert property (lock_evt && overcurrent_lock_response == 4'h8 && !r_reg.lock_fault
    && !sw_clear |=> !r_reg.lock_fault && r_reg.sts[0])
    else $error("report-only lock changed the gates");
  a_lock_disabled: assert property (overcurrent_lock_response > 4'h8 && !r_reg.lock_fault
    |=> !r_reg.lock_fault && !$rose(r_reg.sts[0]))
    else $error("disabled lock detection acted");
  a_latch_holds: assert property (r_reg.lock_latched && !sw_clear |=> r_reg.lock_latched
    && r_reg.lock_fault)
    else $error("latched lock fault dropped without a clear");
  a_irq_level: assert property (r_reg.sts[2] && r_reg.ien[2] |-> irq)
    else $error("enabled undervoltage status did not raise interrupt");

  c_brake: cover property (lock_evt && overcurrent_lock_response == 4'h2);
  c_retry: cover property ($fell(r_reg.lock_fault) && !$past(sw_clear));
  c_retry_latch: cover property ($rose(r_reg.lock_latched) && overcurrent_lock_response >= 4'h4);
  c_uv_fault: cover property ($rose(uv_fault));
endmodule : lbv_top
`default_nettype wire

// >>> verilog/lbv_volt_window.sv
// One side of the bus voltage window with hysteresis recovery.
`timescale 1ns/1ns
`default_nettype none
module lbv_volt_window #(
  parameter bit OVER = 1'b0
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [9:0] volt_dv,
  input  wire logic [9:0] thr_dv,
  input  wire logic [9:0] hys_dv,
  input  wire logic       auto_recover,
  input  wire logic       sw_clear,
  output logic            fault,
  output logic            fault_evt
);
  import lbv_pkg::*;

  lbv_volt_state_type r_reg;
  lbv_volt_state_type r_next;
  logic               bad;
  logic               good;

  // A zero threshold means no limit; auto recovery needs the hysteresis margin.
  always_comb begin
    r_next = r_reg;
    if (OVER) begin
      bad  = thr_dv != 10'h000 && volt_dv > thr_dv;
      good = thr_dv == 10'h000 || volt_dv < thr_dv - hys_dv;
    end else begin
      bad  = thr_dv != 10'h000 && volt_dv < thr_dv;
      good = thr_dv == 10'h000 || volt_dv > thr_dv + hys_dv;
    end
    r_next.evt = bad && !r_reg.fault;
    if (bad) begin
      r_next.fault = 1'b1;
    end else if (auto_recover && good) begin
      r_next.fault = 1'b0;
    end else if (!auto_recover && sw_clear) begin
      r_next.fault = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign fault     = r_reg.fault;
  assign fault_evt = r_reg.evt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A latching fault stays until software clears it.
  a_latch_holds: assert property (fault && !auto_recover && !sw_clear |=> fault)
    else $error("latched bus voltage fault dropped by itself");
  // Auto recovery never happens inside the hysteresis band.
  a_hyst_band: assert property (fault && auto_recover && !good |=> fault)
    else $error("bus voltage fault recovered inside hysteresis");
endmodule : lbv_volt_window
`default_nettype wire
